// ==== smb_index_map.svh ====
// register offsets, reset values and field widths of the index block target
`ifndef SMB_INDEX_MAP_SVH
`define SMB_INDEX_MAP_SVH
`define SMB_REG_GATE 8'h00
`define SMB_REG_BCNT 8'h07
`define SMB_GATE_RST 8'hff
`define SMB_BCNT_RST 5'h08
`define SMB_BCNT_W 5
`define SMB_BIT_LAST 3'h7
`define SMB_BIT_FIRST 3'h0
`define SMB_STRAP_ADDR1 2'h1
`define SMB_STRAP_ADDR2 2'h2
`endif

// ==== smb_pkg.sv ====
// types shared by the index block target
package smb_pkg;
    typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_ackh, st_tx, st_hack, st_tnext} smb_state_t;
    typedef enum logic [1:0] {ph_addr, ph_index, ph_count, ph_data} smb_phase_t;
endpackage : smb_pkg

// ==== smb_index_regs.sv ====
// smbus index block target with output gate and byte count registers
`timescale 1ns/1ps
`include "smb_index_map.svh"

module smb_index_regs #(
    parameter logic [6:0] ADDR0 = 7'h68,
    parameter logic [6:0] ADDR1 = 7'h6a,
    parameter logic [6:0] ADDR2 = 7'h6c,
    parameter int NUM_OUT = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [1:0] target_addr_strap,
    input wire logic [NUM_OUT-1:0] out_gate_pin_n,
    output logic [NUM_OUT-1:0] diff_clock_output_en
);
    import smb_pkg::*;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [7:0] rd_byte(input logic [7:0] idx, input logic [7:0] gate, input logic [4:0] bc);
        logic [7:0] r;
        r = 8'h00;
        if (idx == `SMB_REG_GATE)
            r = gate;
        else if (idx == `SMB_REG_BCNT)
            r = {3'h0, bc};
        return r;
    endfunction : rd_byte

    function automatic logic [6:0] strap_addr(input logic [1:0] s);
        logic [6:0] a;
        a = ADDR0;
        if (s == `SMB_STRAP_ADDR1)
            a = ADDR1;
        else if (s == `SMB_STRAP_ADDR2)
            a = ADDR2;
        return a;
    endfunction : strap_addr

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic scl_m_ff, scl_s_ff, scl_d_ff;
    logic sda_m_ff, sda_s_ff, sda_d_ff;
    logic [1:0] strap_m_ff, strap_s_ff;
    logic [NUM_OUT-1:0] pin_m_ff, pin_s_ff;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            scl_m_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_m_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            pin_m_ff <= '1;
            pin_s_ff <= '1;
        end
        else
        begin
            scl_m_ff <= scl_in;
            scl_s_ff <= scl_m_ff;
            scl_d_ff <= scl_s_ff;
            sda_m_ff <= sda_in;
            sda_s_ff <= sda_m_ff;
            sda_d_ff <= sda_s_ff;
            pin_m_ff <= out_gate_pin_n;
            pin_s_ff <= pin_m_ff;
        end
    end

    // strap synchroniser runs through reset so the latch sees the settled pin
    always_ff @(posedge sys_clk)
    begin
        strap_m_ff <= target_addr_strap;
        strap_s_ff <= strap_m_ff;
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s_ff & ~scl_d_ff;
    assign scl_fall = ~scl_s_ff & scl_d_ff;
    assign bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
    assign bus_stop = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

    // ----------------------------------------
    // protocol state and registers
    // ----------------------------------------
    smb_state_t state_ff, nxt_state;
    smb_phase_t phase_ff, nxt_phase;
    logic [2:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] idx_ff, nxt_idx;
    logic [7:0] rem_ff, nxt_rem;
    logic rd_ff, nxt_rd;
    logic oe_n_ff, nxt_oe_n;
    logic [7:0] gate_ff, nxt_gate;
    logic [`SMB_BCNT_W-1:0] bc_ff, nxt_bc;
    logic [6:0] addr_ff, nxt_addr;
    logic strap_done_ff, nxt_strap_done;
    logic [NUM_OUT-1:0] en_ff, nxt_en;
    logic [7:0] rx_byte;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_idx = idx_ff;
        nxt_rem = rem_ff;
        nxt_rd = rd_ff;
        nxt_oe_n = oe_n_ff;
        nxt_gate = gate_ff;
        nxt_bc = bc_ff;
        nxt_addr = addr_ff;
        nxt_strap_done = 1'b1;
        rx_byte = {shift_ff[6:0], sda_s_ff};
        if (!strap_done_ff)
            nxt_addr = strap_addr(strap_s_ff);
        // output is low/low when gate bit clear, else follows its pin
        nxt_en = gate_ff[NUM_OUT-1:0] & ~pin_s_ff;
        if (bus_stop)
        begin
            nxt_state = st_idle;
            nxt_oe_n = 1'b1;
        end
        else if (bus_start)
        begin
            nxt_state = st_rx;
            nxt_phase = ph_addr;
            nxt_bit_cnt = `SMB_BIT_FIRST;
            nxt_oe_n = 1'b1;
        end
        else
        begin
            case (state_ff)
                st_rx:
                begin
                    if (scl_rise)
                    begin
                        nxt_shift = rx_byte;
                        nxt_bit_cnt = bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == `SMB_BIT_LAST)
                        begin
                            nxt_state = st_ack;
                            case (phase_ff)
                                ph_addr:
                                begin
                                    nxt_rd = rx_byte[0];
                                    if (rx_byte[7:1] != addr_ff)
                                        nxt_state = st_idle;
                                end
                                ph_index:
                                    nxt_idx = rx_byte;
                                ph_count:
                                    nxt_rem = rx_byte;
                                default:
                                begin
                                    if (rem_ff == 8'h00)
                                        nxt_state = st_idle;
                                    else
                                    begin
                                        if (idx_ff == `SMB_REG_GATE)
                                            nxt_gate = rx_byte;
                                        else if (idx_ff == `SMB_REG_BCNT)
                                            nxt_bc = rx_byte[`SMB_BCNT_W-1:0];
                                        nxt_idx = idx_ff + 8'h01;
                                        nxt_rem = rem_ff - 8'h01;
                                    end
                                end
                            endcase
                        end
                    end
                end
                st_ack:
                begin
                    if (scl_fall)
                    begin
                        nxt_oe_n = 1'b0;
                        nxt_state = st_ackh;
                    end
                end
                st_ackh:
                begin
                    if (scl_fall)
                    begin
                        nxt_bit_cnt = `SMB_BIT_FIRST;
                        if (rd_ff && phase_ff == ph_addr)
                        begin
                            nxt_shift = {3'h0, bc_ff};
                            nxt_oe_n = nxt_shift[7];
                            nxt_phase = ph_count;
                            nxt_state = st_tx;
                        end
                        else
                        begin
                            nxt_oe_n = 1'b1;
                            nxt_state = st_rx;
                            case (phase_ff)
                                ph_addr:
                                    nxt_phase = ph_index;
                                ph_index:
                                    nxt_phase = ph_count;
                                default:
                                    nxt_phase = ph_data;
                            endcase
                        end
                    end
                end
                st_tx:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_ff == `SMB_BIT_LAST)
                        begin
                            nxt_oe_n = 1'b1;
                            nxt_state = st_hack;
                        end
                        else
                        begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_oe_n = shift_ff[6];
                            nxt_bit_cnt = bit_cnt_ff + 3'h1;
                        end
                    end
                end
                st_hack:
                begin
                    if (scl_rise)
                    begin
                        if (!sda_s_ff)
                        begin
                            nxt_shift = rd_byte(idx_ff, gate_ff, bc_ff);
                            nxt_idx = idx_ff + 8'h01;
                            nxt_phase = ph_data;
                            nxt_state = st_tnext;
                        end
                        else
                            nxt_state = st_idle;
                    end
                end
                st_tnext:
                begin
                    if (scl_fall)
                    begin
                        nxt_oe_n = shift_ff[7];
                        nxt_bit_cnt = `SMB_BIT_FIRST;
                        nxt_state = st_tx;
                    end
                end
                default:
                    nxt_oe_n = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state_ff <= st_idle;
            phase_ff <= ph_addr;
            bit_cnt_ff <= `SMB_BIT_FIRST;
            shift_ff <= 8'h00;
            idx_ff <= 8'h00;
            rem_ff <= 8'h00;
            rd_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            gate_ff <= `SMB_GATE_RST;
            bc_ff <= `SMB_BCNT_RST;
            addr_ff <= 7'h00;
            strap_done_ff <= 1'b0;
            en_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            idx_ff <= nxt_idx;
            rem_ff <= nxt_rem;
            rd_ff <= nxt_rd;
            oe_n_ff <= nxt_oe_n;
            gate_ff <= nxt_gate;
            bc_ff <= nxt_bc;
            addr_ff <= nxt_addr;
            strap_done_ff <= nxt_strap_done;
            en_ff <= nxt_en;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic sda_out_ff;
    always_ff @(posedge sys_clk)
    begin
        sda_out_ff <= 1'b0;
    end

    assign sda_out = sda_out_ff;
    assign sda_oe_n = oe_n_ff;
    assign diff_clock_output_en = en_ff;
endmodule : smb_index_regs

// ==== smb_index_checker.sv ====
// assertion checker for the index block target
`timescale 1ns/1ps
module smb_index_checker #(
    parameter int NUM_OUT = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [1:0] target_addr_strap,
    input wire logic [NUM_OUT-1:0] out_gate_pin_n,
    input wire logic [NUM_OUT-1:0] diff_clock_output_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> sda_oe_n && diff_clock_output_en == '0)
        else $error("outputs active in reset");
    a_drain_zero: assert property (rst_b [*2] |-> sda_out == 1'b0)
        else $error("data pin driven high");
    a_pin_off: assert property ($stable(out_gate_pin_n) [*4] |-> (diff_clock_output_en & out_gate_pin_n) == '0)
        else $error("output runs with pin high");
    a_drive_bounded: assert property ($fell(sda_oe_n) |-> ##[1:600] sda_oe_n)
        else $error("data pin held too long");
    a_change_clk_low: assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
        else $error("data changed with clock high");
    a_stop_quiet: assert property (scl_in && $rose(sda_in) |=> sda_oe_n [*8])
        else $error("drive after stop");
    a_start_free: assert property (scl_in && $fell(sda_in) |-> sda_oe_n)
        else $error("device pulled start");
    a_ack_lag: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 1) && !$past(scl_in, 2))
        else $error("ack not after clock fall");
    c_ack: cover property ($fell(sda_oe_n));
    c_gate: cover property ($fell(diff_clock_output_en[7]) && !out_gate_pin_n[7]);
    c_stop: cover property (scl_in && $rose(sda_in));
endmodule : smb_index_checker
bind smb_index_regs smb_index_checker #(.NUM_OUT(NUM_OUT)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .target_addr_strap(target_addr_strap), .out_gate_pin_n(out_gate_pin_n),
    .diff_clock_output_en(diff_clock_output_en));

// ==== smb_host_model.sv ====
// smbus host model driving clock and data
`timescale 1ns/1ps
module smb_host_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic step(input logic c, input logic d);
        scl = c;
        sda_drv = d;
        repeat (10) @(posedge sys_clk);
        #1;
    endtask : step
    // start or repeated start, ends with clock low
    task automatic start;
        step(1'b0, sda_drv);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : start
    task automatic xbit(input logic d, output logic q);
        step(1'b0, sda_drv);
        step(1'b0, d);
        step(1'b1, d);
        q = sda_line;
    endtask : xbit
    // eight bits msb first, then the ack bit driven as last
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            xbit(d[i], q[i]);
        xbit(last, ack);
    endtask : xbyte
    task automatic stop;
        step(1'b0, sda_drv);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop
endmodule : smb_host_model

// ==== tb_smbus_index_block_regs.sv ====
// testbench of the index block target
`timescale 1ns/1ps
module tb_smbus_index_block_regs;
    import smb_pkg::*;
    localparam logic [6:0] A0 = 7'h30;
    localparam logic [6:0] A1 = 7'h3a;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] pin_n = 8'h00;
    logic [1:0] strap = 2'h1;
    logic scl, sda_drv, sda_out, sda_oe_n, sda_line, ack;
    logic [7:0] en, q;
    int fail_count = 0;
    int cmp_count = 0;
    always #2 sys_clk = ~sys_clk;
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    smb_index_regs #(.ADDR0(A0), .ADDR1(A1), .ADDR2(7'h44), .NUM_OUT(8)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .target_addr_strap(strap),
        .out_gate_pin_n(pin_n), .diff_clock_output_en(en));
    smb_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] b, input logic acked);
        host.xbyte(b, 1'b1, q, ack);
        chk("ack", {7'h0, ack}, {7'h0, ~acked});
    endtask : wr
    task automatic rd(input logic [7:0] exp, input logic last);
        host.xbyte(8'hff, last, q, ack);
        chk("rdata", q, exp);
    endtask : rd
    task automatic wr_open(input logic [7:0] n, input logic [7:0] x);
        host.start();
        wr({A1, 1'b0}, 1'b1);
        wr(n, 1'b1);
        wr(x, 1'b1);
    endtask : wr_open
    task automatic rd_open(input logic [7:0] n);
        host.start();
        wr({A1, 1'b0}, 1'b1);
        wr(n, 1'b1);
        host.start();
        wr({A1, 1'b1}, 1'b1);
    endtask : rd_open
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 chk("en", en, 8'hff);
        host.start();
        wr({A0, 1'b0}, 1'b0);
        host.stop();
        $display("test address done");
        rd_open(8'h00);
        rd(8'h08, 1'b0);
        rd(8'hff, 1'b0);
        rd(8'h00, 1'b1);
        host.stop();
        $display("test default read done");
        wr_open(8'h00, 8'h01);
        wr(8'h0f, 1'b1);
        chk("en", en, 8'h0f);
        wr(8'h55, 1'b0);
        host.stop();
        chk("en", en, 8'h0f);
        pin_n = 8'h05;
        repeat (4) @(posedge sys_clk);
        #1 chk("en", en, 8'h0a);
        pin_n = 8'h00;
        $display("test gate write done");
        wr_open(8'h06, 8'h02);
        wr(8'h77, 1'b1);
        wr(8'h03, 1'b1);
        host.stop();
        rd_open(8'h06);
        rd(8'h03, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'h03, 1'b1);
        host.stop();
        $display("test count write done");
        strap = 2'h0;
        rst_b = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 chk("en", en, 8'hff);
        host.start();
        wr({A1, 1'b0}, 1'b0);
        host.stop();
        host.start();
        wr({A0, 1'b0}, 1'b1);
        host.stop();
        $display("test strap after reset done");
        print_verdict();
    end
endmodule : tb_smbus_index_block_regs
